/* File: design/mtr_thermal_top.v */
/*
 Motor thermal replica: heating current, first-order model, ambient
 sum, threshold status, and a classic Wishbone register slave.
 Assumes sequence-current magnitudes and the measured ambient come from
 logic on clk_i; the heavy-start input is an asynchronous pin.
*/
// Local design decisions: the address map and register access over Wishbone.
// Function
// RULE1: Equivalent current is sqrt of I1 squared plus weight times I2 squared.
// RULE2: I2 clamps at 1.5 rated current; above it the weight becomes 500%.
// RULE3: Heating time constant while rotating; cooling constant is a percentage at standstill.
// RULE4: Overtemperature rate is squared current term minus overtemperature over time constant.
// RULE5: Reported temperature is overtemperature plus ambient.
// RULE6: A control bit selects measured ambient or the ambient setting.
// RULE7: Alarm, trip and unlock assert when temperature exceeds their thresholds.
// RULE8: Model scaled by rated current, rated temperature, base ambient, time constant.
// RULE9: At power-up overtemperature loads the initial setting, relative to rated overtemperature.
// RULE10: Heavy-start input halves the squared current contribution.
// RULE11: Each step level becomes (1-dt/T) old level plus dt/T current ratio squared.
// RULE12: Trip stays asserted until temperature falls below the unlock threshold.
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.vh"

module mtr_thermal_top #(
    parameter [31:0] TICK_CYCLES = `MTR_TICK_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [15:0] i_pos_i,
    input  wire [15:0] i_neg_i,
    input  wire [15:0] amb_meas_i,
    input  wire        heavy_start_i,
    output reg         alarm_o,
    output reg         trip_o,
    output reg         unlock_o
);
    // ------------------------------------------------------------------
    // State codes and storage
    // ------------------------------------------------------------------
    localparam [4:0] S_IDLE  = 5'h01;
    localparam [4:0] S_RATIO = 5'h02;
    localparam [4:0] S_ALPHA = 5'h04;
    localparam [4:0] S_UPD   = 5'h08;
    localparam [4:0] S_CMP   = 5'h10;

    reg [4:0]  state_r;
    reg        amb_sel_r;
    reg        reload_r;
    reg [15:0] neg_weight_r;
    reg [15:0] heat_tc_r;
    reg [15:0] cool_ratio_r;
    reg [15:0] amb_set_r;
    reg [15:0] alarm_thr_r;
    reg [15:0] trip_thr_r;
    reg [15:0] unlock_thr_r;
    reg [15:0] rated_cur_r;
    reg [15:0] rated_temp_r;
    reg [15:0] base_amb_r;
    reg [15:0] init_ovt_r;
    reg [15:0] still_cur_r;
    reg [31:0] tick_cnt_r;
    reg        tick_pend_r;
    reg        init_pend_r;
    reg        hs_s1_r;
    reg        hs_s2_r;
    reg        hs_s3_r;
    reg        heavy_r;
    reg [31:0] q_r;
    reg [31:0] alpha_r;
    reg [47:0] h_r;
    reg        rot_r;
    reg        clamp_r;
    reg [31:0] temp_r;
    reg        div_start_r;
    reg [63:0] div_num_r;
    reg [47:0] div_den_r;
    reg        sqrt_start_r;
    reg [31:0] rd_nxt;
    wire       div_done;
    wire [63:0] div_quo;
    wire [23:0] eq_cur;

    function [15:0] mtr_wr16;
        input [15:0] old;
        input [15:0] d;
        input [1:0]  be;
        begin
            mtr_wr16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    function [31:0] mtr_sat32;
        input [63:0] v;
        begin
            mtr_sat32 = (|v[63:32]) ? 32'hffffffff : v[31:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Heating current
    // ------------------------------------------------------------------
    wire [16:0] i2_lim  = {1'b0, rated_cur_r} + {2'b00, rated_cur_r[15:1]};
    wire        clamp_w = {1'b0, i_neg_i} > i2_lim; // RULE2
    wire [16:0] i2_eff  = clamp_w ? i2_lim : {1'b0, i_neg_i}; // RULE2
    wire [15:0] k_eff   = clamp_w ? `MTR_CLAMP_WEIGHT : neg_weight_r; // RULE2
    wire [33:0] i2_sq   = i2_eff * i2_eff;
    wire [49:0] k_i2    = k_eff * i2_sq;
    wire [31:0] i1_sq   = i_pos_i * i_pos_i;
    wire [47:0] isq_sum = {16'h0000, i1_sq} + {6'h00, k_i2[49:8]}; // RULE1
    wire [47:0] isq_w   = heavy_r ? {1'b0, isq_sum[47:1]} : isq_sum; // RULE10
    wire [31:0] in_sq   = rated_cur_r * rated_cur_r; // RULE8

    // ------------------------------------------------------------------
    // Time constants
    // ------------------------------------------------------------------
    wire [35:0] t_heat36 = heat_tc_r * `MTR_US_PER_S;
    wire [31:0] tc_pct   = heat_tc_r * cool_ratio_r;
    wire [47:0] t_cool   = tc_pct * `MTR_US_PER_PCT_S;
    wire [47:0] t_sel    = rot_r ? {12'h000, t_heat36} : t_cool; // RULE3

    // ------------------------------------------------------------------
    // Model step
    // ------------------------------------------------------------------
    // The level carries 16 extra fraction bits so that long time constants
    // still move it by a nonzero amount each step.
    wire signed [48:0] diff_w = $signed({1'b0, q_r, 16'h0000}) - $signed({1'b0, h_r});
    wire signed [81:0] prod_w = diff_w * $signed({1'b0, alpha_r});
    wire signed [49:0] hsum_w = $signed({2'b00, h_r}) + $signed(prod_w[81:32]);
    wire [47:0] h_new = hsum_w[49] ? 48'h000000000000 :
                        (hsum_w[48] ? 48'hffffffffffff : hsum_w[47:0]);

    // ------------------------------------------------------------------
    // Temperature and thresholds
    // ------------------------------------------------------------------
    wire signed [16:0] rated_ovt = $signed({rated_temp_r[15], rated_temp_r})
                                 - $signed({base_amb_r[15], base_amb_r}); // RULE8
    wire signed [49:0] theta_p = $signed({1'b0, h_r[47:16]}) * rated_ovt;
    wire signed [33:0] theta_w = theta_p[49:16];
    wire signed [15:0] amb_w   = amb_sel_r ? amb_meas_i : amb_set_r; // RULE6
    wire signed [33:0] temp_w  = theta_w + amb_w; // RULE5
    wire signed [15:0] alm_s   = alarm_thr_r;
    wire signed [15:0] trp_s   = trip_thr_r;
    wire signed [15:0] unl_s   = unlock_thr_r;

    // ------------------------------------------------------------------
    // Arithmetic units
    // ------------------------------------------------------------------
    mtr_div #(
        .NW(64),
        .DW(48)
    ) u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (div_start_r),
        .num_i   (div_num_r),
        .den_i   (div_den_r),
        .done_o  (div_done),
        .quo_o   (div_quo)
    );

    mtr_sqrt #(
        .W(48)
    ) u_sqrt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (sqrt_start_r),
        .rad_i   (isq_sum),
        .done_o  (),
        .root_o  (eq_cur)
    );

    // ------------------------------------------------------------------
    // Calculation tick and heavy-start pin
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= 32'h00000000;
            hs_s1_r    <= 1'b0;
            hs_s2_r    <= 1'b0;
            hs_s3_r    <= 1'b0;
            heavy_r    <= 1'b0;
        end else begin
            tick_cnt_r <= (tick_cnt_r >= TICK_CYCLES - 32'h1) ? 32'h0 : tick_cnt_r + 32'h1;
            hs_s1_r    <= heavy_start_i;
            hs_s2_r    <= hs_s1_r;
            hs_s3_r    <= hs_s2_r;
            if (hs_s2_r == hs_s3_r) begin
                heavy_r <= hs_s3_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Replica sequencer
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        div_start_r  <= 1'b0;
        sqrt_start_r <= 1'b0;
        if (rst_i) begin
            state_r     <= S_IDLE;
            tick_pend_r <= 1'b0;
            init_pend_r <= 1'b1;
            q_r         <= 32'h0;
            alpha_r     <= 32'h0;
            h_r         <= 48'h0;
            rot_r       <= 1'b0;
            clamp_r     <= 1'b0;
            temp_r      <= 32'h0;
            div_num_r   <= 64'h0;
            div_den_r   <= 48'h0;
            alarm_o     <= 1'b0;
            trip_o      <= 1'b0;
            unlock_o    <= 1'b0;
        end else begin
            if (tick_cnt_r == 32'h0) begin
                tick_pend_r <= 1'b1;
            end
            if (reload_r) begin
                init_pend_r <= 1'b1;
            end
            case (state_r)
                S_IDLE: begin
                    if (init_pend_r) begin
                        h_r         <= {8'h00, init_ovt_r, 24'h000000}; // RULE9
                        init_pend_r <= reload_r;
                        state_r     <= S_CMP;
                    end else if (tick_pend_r) begin
                        tick_pend_r  <= (tick_cnt_r == 32'h0);
                        rot_r        <= i_pos_i > still_cur_r; // RULE3
                        clamp_r      <= clamp_w;
                        sqrt_start_r <= 1'b1; // RULE1
                        div_num_r    <= {isq_w[47:0], 16'h0000}; // RULE8
                        div_den_r    <= {16'h0000, in_sq};
                        div_start_r  <= 1'b1;
                        state_r      <= S_RATIO;
                    end
                end
                S_RATIO: begin
                    if (div_done) begin
                        q_r         <= mtr_sat32(div_quo);
                        div_num_r   <= {`MTR_STEP_US, 32'h00000000};
                        div_den_r   <= t_sel; // RULE3
                        div_start_r <= 1'b1;
                        state_r     <= S_ALPHA;
                    end
                end
                S_ALPHA: begin
                    if (div_done) begin
                        alpha_r <= mtr_sat32(div_quo);
                        state_r <= S_UPD;
                    end
                end
                S_UPD: begin
                    h_r     <= h_new; // RULE4 RULE11
                    state_r <= S_CMP;
                end
                S_CMP: begin
                    temp_r   <= temp_w[31:0]; // RULE5
                    alarm_o  <= temp_w > alm_s; // RULE7
                    trip_o   <= (temp_w > trp_s) | (trip_o & ~(temp_w < unl_s)); // RULE7 RULE12
                    unlock_o <= temp_w > unl_s; // RULE7
                    state_r  <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wishbone register slave
    // ------------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr  = wb_req & wb_we_i;

    always @* begin
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `MTR_ADR_CTRL:       rd_nxt = {31'h0, amb_sel_r};
            `MTR_ADR_NEG_WEIGHT: rd_nxt = {16'h0, neg_weight_r};
            `MTR_ADR_HEAT_TC:    rd_nxt = {16'h0, heat_tc_r};
            `MTR_ADR_COOL_RATIO: rd_nxt = {16'h0, cool_ratio_r};
            `MTR_ADR_AMB_SET:    rd_nxt = {16'h0, amb_set_r};
            `MTR_ADR_ALARM_THR:  rd_nxt = {16'h0, alarm_thr_r};
            `MTR_ADR_TRIP_THR:   rd_nxt = {16'h0, trip_thr_r};
            `MTR_ADR_UNLOCK_THR: rd_nxt = {16'h0, unlock_thr_r};
            `MTR_ADR_RATED_CUR:  rd_nxt = {16'h0, rated_cur_r};
            `MTR_ADR_RATED_TEMP: rd_nxt = {16'h0, rated_temp_r};
            `MTR_ADR_BASE_AMB:   rd_nxt = {16'h0, base_amb_r};
            `MTR_ADR_INIT_OVT:   rd_nxt = {16'h0, init_ovt_r};
            `MTR_ADR_STILL_CUR:  rd_nxt = {16'h0, still_cur_r};
            `MTR_ADR_STATUS:     rd_nxt = {26'h0, heavy_r, clamp_r, rot_r,
                                           unlock_o, trip_o, alarm_o};
            `MTR_ADR_TEMP:       rd_nxt = temp_r;
            `MTR_ADR_LEVEL:      rd_nxt = h_r[47:16];
            `MTR_ADR_EQ_CUR:     rd_nxt = {8'h00, eq_cur};
            default:             rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        reload_r <= 1'b0;
        if (rst_i) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0;
            amb_sel_r    <= 1'b0;
            neg_weight_r <= `MTR_RST_WEIGHT;
            heat_tc_r    <= `MTR_RST_HEAT_TC;
            cool_ratio_r <= `MTR_RST_COOL_RATIO;
            amb_set_r    <= `MTR_RST_AMB_SET;
            alarm_thr_r  <= `MTR_RST_ALARM_THR;
            trip_thr_r   <= `MTR_RST_TRIP_THR;
            unlock_thr_r <= `MTR_RST_UNLOCK_THR;
            rated_cur_r  <= `MTR_RST_RATED_CUR;
            rated_temp_r <= `MTR_RST_RATED_TEMP;
            base_amb_r   <= `MTR_RST_BASE_AMB;
            init_ovt_r   <= `MTR_RST_INIT_OVT;
            still_cur_r  <= `MTR_RST_STILL_CUR;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= wb_we_i ? 32'h0 : rd_nxt;
            end
            if (wb_wr) begin
                case (wb_adr_i)
                    `MTR_ADR_CTRL: begin
                        if (wb_sel_i[0]) begin
                            amb_sel_r <= wb_dat_i[`MTR_CTRL_AMB_SEL]; // RULE6
                            reload_r  <= wb_dat_i[`MTR_CTRL_RELOAD];
                        end
                    end
                    `MTR_ADR_NEG_WEIGHT: neg_weight_r <= mtr_wr16(neg_weight_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_HEAT_TC:    heat_tc_r    <= mtr_wr16(heat_tc_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_COOL_RATIO: cool_ratio_r <= mtr_wr16(cool_ratio_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_AMB_SET:    amb_set_r    <= mtr_wr16(amb_set_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_ALARM_THR:  alarm_thr_r  <= mtr_wr16(alarm_thr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_TRIP_THR:   trip_thr_r   <= mtr_wr16(trip_thr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_UNLOCK_THR: unlock_thr_r <= mtr_wr16(unlock_thr_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_RATED_CUR:  rated_cur_r  <= mtr_wr16(rated_cur_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_RATED_TEMP: rated_temp_r <= mtr_wr16(rated_temp_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_BASE_AMB:   base_amb_r   <= mtr_wr16(base_amb_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_INIT_OVT:   init_ovt_r   <= mtr_wr16(init_ovt_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    `MTR_ADR_STILL_CUR:  still_cur_r  <= mtr_wr16(still_cur_r, wb_dat_i[15:0], wb_sel_i[1:0]);
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

/* File: design/mtr_defines.vh */
/*
 Constants of the motor thermal replica: register byte offsets, field
 positions, reset values and the calculation timing.
 Assumes a 200 MHz system clock and a 32-bit Wishbone register bus.
*/
`ifndef MTR_DEFINES_VH
`define MTR_DEFINES_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define MTR_ADR_CTRL        8'h00
`define MTR_ADR_NEG_WEIGHT  8'h04
`define MTR_ADR_HEAT_TC     8'h08
`define MTR_ADR_COOL_RATIO  8'h0c
`define MTR_ADR_AMB_SET     8'h10
`define MTR_ADR_ALARM_THR   8'h14
`define MTR_ADR_TRIP_THR    8'h18
`define MTR_ADR_UNLOCK_THR  8'h1c
`define MTR_ADR_RATED_CUR   8'h20
`define MTR_ADR_RATED_TEMP  8'h24
`define MTR_ADR_BASE_AMB    8'h28
`define MTR_ADR_INIT_OVT    8'h2c
`define MTR_ADR_STILL_CUR   8'h30
`define MTR_ADR_STATUS      8'h34
`define MTR_ADR_TEMP        8'h38
`define MTR_ADR_LEVEL       8'h3c
`define MTR_ADR_EQ_CUR      8'h40

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define MTR_CTRL_AMB_SEL    0
`define MTR_CTRL_RELOAD     1
`define MTR_ST_ALARM        0
`define MTR_ST_TRIP         1
`define MTR_ST_UNLOCK       2
`define MTR_ST_ROT          3
`define MTR_ST_CLAMP        4
`define MTR_ST_HEAVY        5

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define MTR_RST_WEIGHT      16'h0100
`define MTR_RST_HEAT_TC     16'h003c
`define MTR_RST_COOL_RATIO  16'h012c
`define MTR_RST_AMB_SET     16'h0019
`define MTR_RST_ALARM_THR   16'h0050
`define MTR_RST_TRIP_THR    16'h005a
`define MTR_RST_UNLOCK_THR  16'h0046
`define MTR_RST_RATED_CUR   16'h0100
`define MTR_RST_RATED_TEMP  16'h0064
`define MTR_RST_BASE_AMB    16'h0028
`define MTR_RST_INIT_OVT    16'h0000
`define MTR_RST_STILL_CUR   16'h0010

// ------------------------------------------------------------------
// Scaling and timing
// ------------------------------------------------------------------
`define MTR_CLAMP_WEIGHT    16'h0500
`define MTR_CLK_MHZ         32'h000000c8
`define MTR_STEP_US         32'h000003e8
`define MTR_TICK_CYCLES     (`MTR_STEP_US * `MTR_CLK_MHZ)
`define MTR_US_PER_S        36'h00000f4240
`define MTR_US_PER_PCT_S    16'h2710

`endif

/* File: design/mtr_div.v */
/*
 Sequential restoring divider, one quotient bit per clock.
 Assumes start_i is a single-cycle pulse given only while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module mtr_div #(
    parameter NW = 64,
    parameter DW = 48
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          start_i,
    input  wire [NW-1:0] num_i,
    input  wire [DW-1:0] den_i,
    output reg           done_o,
    output reg  [NW-1:0] quo_o
);
    localparam [7:0] NW8 = NW;

    reg [DW:0]   rem_r;
    reg [DW-1:0] den_r;
    reg [7:0]    cnt_r;
    reg          busy_r;

    wire [DW:0] shl_w = {rem_r[DW-1:0], quo_o[NW-1]};
    wire [DW:0] sub_w = shl_w - {1'b0, den_r};

    // A zero divisor yields ones in the top 48 quotient bits, which the caller reads as saturation.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            rem_r  <= {(DW+1){1'b0}};
            den_r  <= {DW{1'b0}};
            cnt_r  <= 8'h00;
            busy_r <= 1'b0;
            quo_o  <= {NW{1'b0}};
        end else if (start_i) begin
            rem_r  <= {(DW+1){1'b0}};
            den_r  <= den_i;
            cnt_r  <= NW8;
            busy_r <= 1'b1;
            quo_o  <= num_i;
        end else if (busy_r) begin
            if (!sub_w[DW]) begin
                rem_r <= sub_w;
                quo_o <= {quo_o[NW-2:0], 1'b1};
            end else begin
                rem_r <= shl_w;
                quo_o <= {quo_o[NW-2:0], 1'b0};
            end
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
                busy_r <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: design/mtr_sqrt.v */
/*
 Sequential integer square root, two radicand bits per clock.
 Assumes W is even and start_i is a single-cycle pulse given while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module mtr_sqrt #(
    parameter W = 48
) (
    input  wire           clk_i,
    input  wire           rst_i,
    input  wire           start_i,
    input  wire [W-1:0]   rad_i,
    output reg            done_o,
    output reg  [W/2-1:0] root_o
);
    reg [W-1:0] x_r;
    reg [W-1:0] res_r;
    reg [W-1:0] bit_r;
    reg         busy_r;

    wire [W-1:0] trial_w = res_r + bit_r;
    wire [W-1:0] res_sh  = {1'b0, res_r[W-1:1]};
    wire         take_w  = (x_r >= trial_w);
    wire [W-1:0] res_nxt = take_w ? res_sh + bit_r : res_sh;

    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            x_r    <= {W{1'b0}};
            res_r  <= {W{1'b0}};
            bit_r  <= {W{1'b0}};
            busy_r <= 1'b0;
            root_o <= {(W/2){1'b0}};
        end else if (start_i) begin
            x_r    <= rad_i;
            res_r  <= {W{1'b0}};
            bit_r  <= {2'b01, {(W-2){1'b0}}};
            busy_r <= 1'b1;
        end else if (busy_r) begin
            if (take_w) begin
                x_r <= x_r - trial_w;
            end
            res_r <= res_nxt;
            bit_r <= {2'b00, bit_r[W-1:2]};
            if (bit_r[0]) begin
                busy_r <= 1'b0;
                done_o <= 1'b1;
                root_o <= res_nxt[W/2-1:0];
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/mtr_thermal_asserts.sv */
/* Checker for the motor thermal replica top: bus answer timing and status outputs.
   Assumes binding to mtr_thermal_top and thresholds kept as unlock < alarm < trip. */
`timescale 1ns/1ps
`default_nettype none
module mtr_thermal_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        alarm_o,
    input wire logic        trip_o,
    input wire logic        unlock_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Order properties hold only for ordered thresholds, which the bench keeps.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ANSWER: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no answer");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_WR_ZERO: assert property (
        wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0) else $error("write data not zero");
    AST_RD_UPPER: assert property (
        wb_ack_o && wb_adr_i < 8'h38 |-> wb_dat_o[31:16] == 16'h0) else $error("upper half set");
    AST_RST_CLEAR: assert property (
        $fell(rst_i) |-> !alarm_o && !trip_o && !unlock_o) else $error("outputs after reset");
    AST_OUT_HOLD: assert property (
        $changed({alarm_o, trip_o, unlock_o}) |=> $stable({alarm_o, trip_o, unlock_o})[*8])
        else $error("status changed between steps");
    AST_TRIP_SET: assert property (
        $rose(trip_o) |-> alarm_o && unlock_o) else $error("trip without alarm");
    AST_TRIP_CLEAR: assert property (
        $fell(trip_o) |-> !unlock_o) else $error("trip released above unlock");
    AST_ALARM_UNLOCK: assert property (
        alarm_o |-> unlock_o) else $error("alarm without unlock");
    cover property ($rose(trip_o));
    cover property ($fell(trip_o));
    cover property ($rose(alarm_o));
endmodule
bind mtr_thermal_top mtr_thermal_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_o(alarm_o), .trip_o(trip_o),
    .unlock_o(unlock_o));
`default_nettype wire

/* File: verification/tb_mtr_thermal_top.sv */
/* Self-checking bench for the motor thermal replica top.
   Assumes mtr_defines.vh on the include path and a shortened tick of 200 clocks. */
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.vh"
module tb_mtr_thermal_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, heavy_start_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        wb_ack_o, alarm_o, trip_o, unlock_o, h;
    logic [7:0]  wb_adr_i = 8'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, lv;
    logic [15:0] i_pos_i = 16'h0, i_neg_i = 16'h0, amb_meas_i = 16'h0, p, n, e;
    logic [2:0]  s;
    integer      mismatches = 0, check_count = 0, i;
    logic [15:0] rv [13] = '{16'h0, `MTR_RST_WEIGHT, `MTR_RST_HEAT_TC, `MTR_RST_COOL_RATIO,
        `MTR_RST_AMB_SET, `MTR_RST_ALARM_THR, `MTR_RST_TRIP_THR, `MTR_RST_UNLOCK_THR,
        `MTR_RST_RATED_CUR, `MTR_RST_RATED_TEMP, `MTR_RST_BASE_AMB, `MTR_RST_INIT_OVT,
        `MTR_RST_STILL_CUR};
    // Rows: positive, negative, heavy start, root, status bits heavy/clamp/rotating.
    logic [51:0] row [4] = '{{16'h00c0, 16'h0100, 1'b0, 16'h0140, 3'b001},
        {16'h00c0, 16'h0180, 1'b0, 16'h01ad, 3'b001},
        {16'h00c0, 16'h0200, 1'b0, 16'h036f, 3'b011},
        {16'h0010, 16'h0000, 1'b1, 16'h0010, 3'b100}};
    mtr_thermal_top #(.TICK_CYCLES(32'h000000c8)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .i_pos_i(i_pos_i), .i_neg_i(i_neg_i), .amb_meas_i(amb_meas_i),
        .heavy_start_i(heavy_start_i), .alarm_o(alarm_o), .trip_o(trip_o), .unlock_o(unlock_o));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Temperature may sit one degree low because the level is truncated.
    task automatic th(input logic [15:0] t, input logic [2:0] o);
        repeat (450) @(posedge clk_i);
        wb(1'b0, `MTR_ADR_TEMP, 32'h0);
        chk("temperature", 1'b1, q[15:0] <= t && q[15:0] + 16'h1 >= t);
        chk("alarm trip unlock", o, {alarm_o, trip_o, unlock_o});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("outputs after reset", 3'b000, {alarm_o, trip_o, unlock_o});
        for (i = 0; i < 13; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", {16'h0, rv[i]}, q);
        end
        wb(1'b1, 8'h44, 32'h0000ffff);
        wb(1'b0, 8'h44, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, `MTR_ADR_TEMP, 32'h00007777);
        for (i = 0; i < 4; i++) begin
            {p, n, h, e, s} = row[i];
            i_pos_i <= p;
            i_neg_i <= n;
            heavy_start_i <= h;
            repeat (450) @(posedge clk_i);
            wb(1'b0, `MTR_ADR_EQ_CUR, 32'h0);
            chk("equivalent current", {16'h0, e}, q);
            wb(1'b0, `MTR_ADR_STATUS, 32'h0);
            chk("status bits", s, q[5:3]);
        end
        i_pos_i <= 16'h0100;
        heavy_start_i <= 1'b0;
        amb_meas_i <= 16'h0028;
        wb(1'b1, `MTR_ADR_INIT_OVT, 32'h00000100);
        wb(1'b1, `MTR_ADR_CTRL, 32'h00000002);
        th(16'h0055, 3'b101);
        for (i = 0; i < 2; i++) begin
            wb(1'b0, `MTR_ADR_LEVEL, 32'h0);
            lv = q;
            i_pos_i <= 16'h0200;
            heavy_start_i <= i[0];
            repeat (1000) @(posedge clk_i);
            i_pos_i <= 16'h0100;
            wb(1'b0, `MTR_ADR_LEVEL, 32'h0);
            p = i ? 16'h0003 : 16'h000a;
            n = i ? 16'h000c : 16'h0016;
            chk("level rise", 1'b1, q - lv >= p && q - lv <= n);
        end
        heavy_start_i <= 1'b0;
        wb(1'b1, `MTR_ADR_CTRL, 32'h00000001);
        th(16'h0064, 3'b111);
        amb_meas_i <= 16'h000f;
        th(16'h004b, 3'b011);
        amb_meas_i <= 16'h0005;
        th(16'h0041, 3'b000);
        i_pos_i <= 16'h0000;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        th(16'h0019, 3'b000);
        print_verdict;
    end
endmodule
`default_nettype wire
